// >>> rtl/port_t_defs.svh
// Register offsets, field positions, reset values and timing counts for the port T block
//
// How it works
// - Register reads use only bus-clock-synchronised values
// - Data read: latch if direction 1, else pin
// - Timer output channel takes over its pin
// - Pins 4..0: pulse, then timer, then general output
// - Timer active needs enable, compare mode, routing
// - Pin level register reads pins, ignores writes
// - Direction bit 0 input, 1 output
// - Peripheral forces output, stored direction untouched
// - Direction returns to software when timer disabled
// - Capture path always sees the pin level
// - Reads may lag direction change three cycles
// - Drive bit 1 reduced, ignored on inputs
// - Pull enable acts only on input pins
// - Pull enables clear after reset
// - Polarity 0 pull-up, 1 pull-down
// - Routing 0 timer, 1 pulse-width module
`ifndef PORT_T_DEFS_SVH
`define PORT_T_DEFS_SVH

`define PT_PINS 8
`define PT_PWM_PINS 5

// Register indices; the byte address is four times the index
`define PT_IDX_OUTPUT_DATA 4'h0
`define PT_IDX_PIN_LEVEL 4'h1
`define PT_IDX_DIRECTION 4'h2
`define PT_IDX_DRIVE_STRENGTH 4'h3
`define PT_IDX_PULL_ENABLE 4'h4
`define PT_IDX_PULL_POLARITY 4'h5
`define PT_IDX_ROUTING 4'h7
`define PT_IDX_EFFECTIVE_DIR 4'h8
`define PT_IDX_TIMER_ACTIVE 4'h9
`define PT_IDX_PULSE_ACTIVE 4'hA

// Bus address field
`define PT_ADDR_W 6
`define PT_IDX_MSB 5
`define PT_IDX_LSB 2

// Reset values
`define PT_RST_OUTPUT_DATA 8'h00
`define PT_RST_DIRECTION 8'h00
`define PT_RST_DRIVE_STRENGTH 8'h00
`define PT_RST_PULL_ENABLE 8'h00
`define PT_RST_PULL_POLARITY 8'h00
`define PT_RST_ROUTING 5'h00

// Avalon response codes
`define PT_RESP_OKAY 2'h0
`define PT_RESP_DECODEERROR 2'h3

// Pin synchroniser depth in bus cycles
`define PT_SYNC_STAGES 2

`endif

// >>> rtl/port_t_pkg.sv
// Types shared by the port T pin integration block
package port_t_pkg;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_e;

  // Timer configuration as seen by the pin logic
  typedef struct packed {
    logic enable;
    logic [7:0] func_sel;
    logic [7:0] ovf_toggle;
    logic [7:0] action_high;
    logic [7:0] action_low;
  } timer_cfg_s;

  // Pad controls for all eight pins
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
    logic [7:0] reduced;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
  } pin_drive_s;

endpackage : port_t_pkg

// >>> rtl/port_t_sync.sv
// Two-stage synchroniser for the eight port T pin levels
`timescale 1ns/10ps
`include "port_t_defs.svh"
module port_t_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] async_i,
  output logic [7:0] sync_o
);
  logic [7:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 8'h00;
      sync_o <= 8'h00;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : port_t_sync

// >>> rtl/port_t_output_select.sv
// Per-pin output source and direction override for port T
`timescale 1ns/10ps
`include "port_t_defs.svh"
module port_t_output_select (
  input port_t_pkg::timer_cfg_s timer_cfg_i,
  input wire logic [4:0] routing_i,
  input wire logic [4:0] pulse_enable_i,
  output logic [7:0] timer_active_o,
  output logic [4:0] pulse_active_o
);
  import port_t_pkg::*;

  // Two action bits per channel; any non-zero action drives the pin
  function automatic logic action_routed(input logic [1:0] action);
    action_routed = (action != 2'h0);
  endfunction : action_routed

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      timer_active_o[i] = timer_cfg_i.enable
        & (timer_cfg_i.func_sel[i] | timer_cfg_i.ovf_toggle[i])
        & action_routed(timer_cfg_i.action_low[2*i +: 2]);
      timer_active_o[i+4] = timer_cfg_i.enable
        & (timer_cfg_i.func_sel[i+4] | timer_cfg_i.ovf_toggle[i+4])
        & action_routed(timer_cfg_i.action_high[2*i +: 2]);
    end
  end

  // Pulse channel wins only when routed there and enabled
  assign pulse_active_o = routing_i & pulse_enable_i;
endmodule : port_t_output_select

// >>> rtl/port_t_pin_integration.sv
// Port T pin integration: registers, Avalon-MM slave and pad control
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`include "port_t_defs.svh"
module port_t_pin_integration (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [`PT_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // Timer and pulse-width module side
  input port_t_pkg::timer_cfg_s timer_cfg_i,
  input wire logic [7:0] compare_channel_output_i,
  input wire logic [4:0] pulse_channel_enable_i,
  input wire logic [4:0] pulse_channel_output_i,
  output logic [7:0] capture_level_o,
  // Pads
  input wire logic [7:0] pin_i,
  output port_t_pkg::pin_drive_s pin_drive_o
);
  import port_t_pkg::*;

  bus_state_e bus_state_r;
  bus_state_e bus_state_nxt;

  logic [7:0] port_t_output_data_r;
  logic [7:0] port_t_direction_r;
  logic [7:0] port_t_drive_strength_r;
  logic [7:0] port_t_pull_enable_r;
  logic [7:0] port_t_pull_polarity_r;
  logic [4:0] pin_routing_select_r;

  logic [7:0] pin_sync;
  logic [7:0] timer_active;
  logic [4:0] pulse_active;
  logic [7:0] eff_dir;
  logic [7:0] out_level;
  logic [7:0] pulse_wide;

  logic [3:0] req_idx;
  logic req;
  logic accept;
  logic wr_en;
  logic idx_mapped;
  logic [7:0] rd_byte;

  // Pin levels cross into the bus clock before anything reads them
  port_t_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  port_t_output_select u_select (
    .timer_cfg_i(timer_cfg_i),
    .routing_i(pin_routing_select_r),
    .pulse_enable_i(pulse_channel_enable_i),
    .timer_active_o(timer_active),
    .pulse_active_o(pulse_active)
  );

  // Bus decode
  function automatic logic is_mapped(input logic [3:0] idx);
    case (idx)
      `PT_IDX_OUTPUT_DATA,
      `PT_IDX_PIN_LEVEL,
      `PT_IDX_DIRECTION,
      `PT_IDX_DRIVE_STRENGTH,
      `PT_IDX_PULL_ENABLE,
      `PT_IDX_PULL_POLARITY,
      `PT_IDX_ROUTING,
      `PT_IDX_EFFECTIVE_DIR,
      `PT_IDX_TIMER_ACTIVE,
      `PT_IDX_PULSE_ACTIVE: is_mapped = 1'h1;
      default: is_mapped = 1'h0;
    endcase
  endfunction : is_mapped

  // Write strobe for one register index, shared by every software register below
  function automatic logic reg_hit(input logic en, input logic [3:0] idx,
    input logic [3:0] sel);
    reg_hit = en & (idx == sel);
  endfunction : reg_hit

  assign req_idx = avs_address_i[`PT_IDX_MSB:`PT_IDX_LSB];
  assign req = avs_read_i | avs_write_i;
  // The master completes on the edge where waitrequest is low
  assign accept = (bus_state_r == BUS_ANSWER) & req;
  // Only byte lane 0 carries register data
  assign wr_en = accept & avs_write_i & avs_byteenable_i[0];
  assign idx_mapped = is_mapped(req_idx);

  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE: begin
        if (req) begin
          bus_state_nxt = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        bus_state_nxt = BUS_IDLE;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // Waitrequest is high except in the single answer cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'h1;
    end else begin
      avs_waitrequest_o <= !((bus_state_r == BUS_IDLE) & req);
    end
  end

  // Software registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_t_output_data_r <= `PT_RST_OUTPUT_DATA;
    end else if (reg_hit(wr_en, req_idx, `PT_IDX_OUTPUT_DATA)) begin
      port_t_output_data_r <= avs_writedata_i[7:0];
    end
  end

  // Overrides act on the pad only; this register keeps the software value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_t_direction_r <= `PT_RST_DIRECTION;
    end else if (reg_hit(wr_en, req_idx, `PT_IDX_DIRECTION)) begin
      port_t_direction_r <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_t_drive_strength_r <= `PT_RST_DRIVE_STRENGTH;
    end else if (reg_hit(wr_en, req_idx, `PT_IDX_DRIVE_STRENGTH)) begin
      port_t_drive_strength_r <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_t_pull_enable_r <= `PT_RST_PULL_ENABLE;
    end else if (reg_hit(wr_en, req_idx, `PT_IDX_PULL_ENABLE)) begin
      port_t_pull_enable_r <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_t_pull_polarity_r <= `PT_RST_PULL_POLARITY;
    end else if (reg_hit(wr_en, req_idx, `PT_IDX_PULL_POLARITY)) begin
      port_t_pull_polarity_r <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_routing_select_r <= `PT_RST_ROUTING;
    end else if (reg_hit(wr_en, req_idx, `PT_IDX_ROUTING)) begin
      pin_routing_select_r <= avs_writedata_i[4:0];
    end
  end

  // Output source and direction
  assign pulse_wide = {3'h0, pulse_active};

  // Hardware override is recomputed every cycle, so dropping the
  // timer or pulse enable hands the pin straight back to software
  assign eff_dir = port_t_direction_r | timer_active | pulse_wide;

  always_comb begin
    for (int i = 0; i < `PT_PINS; i++) begin
      if (pulse_wide[i]) begin
        out_level[i] = 1'h0;
      end else if (timer_active[i]) begin
        out_level[i] = compare_channel_output_i[i];
      end else begin
        out_level[i] = port_t_output_data_r[i];
      end
    end
    for (int j = 0; j < `PT_PWM_PINS; j++) begin
      if (pulse_active[j]) begin
        out_level[j] = pulse_channel_output_i[j];
      end
    end
  end

  // Pad controls are registered so the pads see no decode glitches
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_drive_o.level <= 8'h00;
      pin_drive_o.oe_n <= 8'hFF;
      pin_drive_o.reduced <= 8'h00;
      pin_drive_o.pull_en <= 8'h00;
      pin_drive_o.pull_down <= 8'h00;
    end else begin
      pin_drive_o.level <= out_level;
      pin_drive_o.oe_n <= ~eff_dir;
      pin_drive_o.reduced <= port_t_drive_strength_r & eff_dir;
      pin_drive_o.pull_en <= port_t_pull_enable_r & ~eff_dir;
      pin_drive_o.pull_down <= port_t_pull_polarity_r & port_t_pull_enable_r
        & ~eff_dir;
    end
  end

  // Capture sees the pin whatever drives it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_level_o <= 8'h00;
    end else begin
      capture_level_o <= pin_sync;
    end
  end

  // Read path
  // Pin levels trail the pads by the synchroniser, hence the short
  // stale window after a direction change
  always_comb begin
    case (req_idx)
      `PT_IDX_OUTPUT_DATA: begin
        rd_byte = (port_t_direction_r & port_t_output_data_r)
          | (~port_t_direction_r & pin_sync);
      end
      `PT_IDX_PIN_LEVEL: rd_byte = pin_sync;
      `PT_IDX_DIRECTION: rd_byte = port_t_direction_r;
      `PT_IDX_DRIVE_STRENGTH: rd_byte = port_t_drive_strength_r;
      `PT_IDX_PULL_ENABLE: rd_byte = port_t_pull_enable_r;
      `PT_IDX_PULL_POLARITY: rd_byte = port_t_pull_polarity_r;
      `PT_IDX_ROUTING: rd_byte = {3'h0, pin_routing_select_r};
      `PT_IDX_EFFECTIVE_DIR: rd_byte = eff_dir;
      `PT_IDX_TIMER_ACTIVE: rd_byte = timer_active;
      `PT_IDX_PULSE_ACTIVE: rd_byte = pulse_wide;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is captured in the idle cycle and stands in the answer cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_state_r == BUS_IDLE && avs_read_i) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_response_o <= `PT_RESP_OKAY;
    end else if (bus_state_r == BUS_IDLE && req) begin
      avs_response_o <= idx_mapped ? `PT_RESP_OKAY : `PT_RESP_DECODEERROR;
    end
  end

endmodule : port_t_pin_integration

// >>> tb/port_t_chk_sva.sv
// Checker for port T bus timing and pad control
`timescale 1ns/10ps
module port_t_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input port_t_pkg::timer_cfg_s timer_cfg_i,
  input wire logic [7:0] compare_channel_output_i,
  input wire logic [4:0] pulse_channel_enable_i,
  input wire logic [7:0] capture_level_o,
  input wire logic [7:0] pin_i,
  input port_t_pkg::pin_drive_s pin_drive_o
);
  import port_t_pkg::*;
  logic [15:0] act;
  logic [7:0] ta;
  logic [7:0] m;
  logic [1:0] up_r;
  assign act = {timer_cfg_i.action_high, timer_cfg_i.action_low};
  // Pins whose pulse enable is set may be routed away from the timer
  assign m = ta & ~{3'h0, pulse_channel_enable_i};
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ta[i] = timer_cfg_i.enable & (timer_cfg_i.func_sel[i] | timer_cfg_i.ovf_toggle[i])
        & (|act[2*i +: 2]);
    end
  end
  // Edges since reset release, so $past never looks into reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("Request not answered");
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("Answer too long");
  property p_timer_src;
    up_r != 2'h0 |-> ((pin_drive_o.level ^ $past(compare_channel_output_i)) & $past(m)) == 8'h00;
  endproperty
  a_timer_src: assert property (p_timer_src) else $error("Pin not from timer");
  property p_force_out;
    up_r != 2'h0 |-> (pin_drive_o.oe_n & $past(ta)) == 8'h00;
  endproperty
  a_force_out: assert property (p_force_out) else $error("Timer pin not output");
  property p_reduced;
    (pin_drive_o.reduced & pin_drive_o.oe_n) == 8'h00;
  endproperty
  a_reduced: assert property (p_reduced) else $error("Reduced drive on input");
  property p_pull_in;
    (pin_drive_o.pull_en & ~pin_drive_o.oe_n) == 8'h00;
  endproperty
  a_pull_in: assert property (p_pull_in) else $error("Pull on output pin");
  property p_pull_pol;
    (pin_drive_o.pull_down & ~pin_drive_o.pull_en) == 8'h00;
  endproperty
  a_pull_pol: assert property (p_pull_pol) else $error("Pull-down without pull");
  property p_pull_rst;
    $rose(rst_n_i) |-> pin_drive_o.pull_en == 8'h00;
  endproperty
  a_pull_rst: assert property (p_pull_rst) else $error("Pull active after reset");
  property p_capture;
    up_r == 2'h3 |-> capture_level_o == $past(pin_i, 3);
  endproperty
  a_capture: assert property (p_capture) else $error("Capture level wrong");
endmodule : port_t_chk

// >>> tb/port_t_pads.sv
// Pad model: each pin is driven by the pad, the board or its pull device, else it floats
`timescale 1ns/10ps
module port_t_pads (
  input port_t_pkg::pin_drive_s drive_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_o
);
  import port_t_pkg::*;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!drive_i.oe_n[i]) begin
        pin_o[i] = drive_i.level[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_i[i];
      end else if (drive_i.pull_en[i]) begin
        pin_o[i] = ~drive_i.pull_down[i];
      end else begin
        // Floating line must not look like a stable level
        pin_o[i] = ~drive_i.level[i];
      end
    end
  end
endmodule : port_t_pads

// >>> tb/tb.sv
// Self-checking bench for the port T pin integration block
`timescale 1ns/10ps
`include "port_t_defs.svh"
module tb;
  import port_t_pkg::*;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [`PT_ADDR_W-1:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic [1:0] resp;
  logic wt;
  timer_cfg_s cfg = 33'h0;
  logic [7:0] cmp = 8'h00;
  logic [4:0] pen = 5'h00;
  logic [4:0] pout = 5'h00;
  logic [7:0] cap;
  logic [7:0] pin;
  pin_drive_s drv;
  logic [7:0] ext = 8'hA5;
  logic [7:0] ext_en = 8'hFF;
  logic [31:0] tmp;
  int n_errors = 0;
  int comparisons = 0;

  port_t_pin_integration port_t_pin_integration_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_response_o(resp),
    .avs_waitrequest_o(wt), .timer_cfg_i(cfg), .compare_channel_output_i(cmp),
    .pulse_channel_enable_i(pen), .pulse_channel_output_i(pout), .capture_level_o(cap),
    .pin_i(pin), .pin_drive_o(drv));
  port_t_pads port_t_pads_i (.drive_i(drv), .ext_i(ext), .ext_en_i(ext_en), .pin_o(pin));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: expected %0h got %0h", $time, exp, got);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    addr <= {idx, 2'h0};
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, d};
    do @(posedge clk_i); while (wt !== 1'h0);
    tmp = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask : bus

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 8'h00);
    chk(exp, tmp[7:0]);
  endtask : rdchk

  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rdchk(4'h0, 8'hA5);
    rdchk(4'h1, 8'hA5);
    rdchk(4'h4, 8'h00);
    chk(8'h00, {6'h00, resp});
    bus(1'h1, 4'h1, 8'hFF);
    rdchk(4'h1, 8'hA5);
    rdchk(4'h6, 8'h00);
    chk(8'h03, {6'h00, resp});
    // Only byte lane 0 carries register data, so this write is dropped
    be <= 4'hE;
    bus(1'h1, 4'h4, 8'hFF);
    be <= 4'hF;
    rdchk(4'h4, 8'h00);
    bus(1'h1, 4'h0, 8'h3C);
    bus(1'h1, 4'h2, 8'hF0);
    // Pin reads lag a direction change by the pad register plus the synchroniser depth
    repeat (4) @(posedge clk_i);
    rdchk(4'h0, 8'h35);
    rdchk(4'h1, 8'h35);
    chk(8'h0F, drv.oe_n);
    bus(1'h1, 4'h3, 8'hFF);
    bus(1'h1, 4'h4, 8'hFF);
    bus(1'h1, 4'h5, 8'h0F);
    ext_en <= 8'hF0;
    repeat (4) @(posedge clk_i);
    chk(8'hF0, drv.reduced);
    chk(8'h0F, drv.pull_en);
    chk(8'h0F, drv.pull_down);
    rdchk(4'h1, 8'h30);
    bus(1'h1, 4'h5, 8'h03);
    repeat (4) @(posedge clk_i);
    rdchk(4'h1, 8'h3C);
    // Pin 2 lacks an output action and pin 3 lacks a compare mode
    cfg.enable <= 1'h1;
    cfg.func_sel <= 8'h06;
    cfg.ovf_toggle <= 8'h40;
    cfg.action_low <= 8'h44;
    cfg.action_high <= 8'h10;
    cmp <= 8'h42;
    repeat (2) @(posedge clk_i);
    chk(8'h7E, drv.level);
    chk(8'h0D, drv.oe_n);
    rdchk(4'h2, 8'hF0);
    rdchk(4'h8, 8'hF2);
    rdchk(4'h9, 8'h42);
    bus(1'h1, 4'h7, 8'h01);
    pen <= 5'h03;
    pout <= 5'h01;
    repeat (2) @(posedge clk_i);
    chk(8'h7F, drv.level);
    chk(8'h0C, drv.oe_n);
    rdchk(4'hA, 8'h01);
    rdchk(4'h7, 8'h01);
    rdchk(4'h8, 8'hF3);
    cfg.enable <= 1'h0;
    pen <= 5'h00;
    repeat (2) @(posedge clk_i);
    chk(8'h0F, drv.oe_n);
    chk(8'h3C, drv.level);
    rdchk(4'h9, 8'h00);
    chk(8'h3C, cap);
    // A second reset must clear the pull enables written above
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk(8'hFF, drv.oe_n);
    rdchk(4'h4, 8'h00);
    rdchk(4'h1, 8'hAF);
    finish_test();
  end

  // The sequence needs about 115 cycles; this span of 2500 cycles is far beyond it
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
endmodule : tb

bind port_t_pin_integration port_t_chk port_t_chk_i (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .timer_cfg_i(timer_cfg_i),
  .compare_channel_output_i(compare_channel_output_i),
  .pulse_channel_enable_i(pulse_channel_enable_i),
  .capture_level_o(capture_level_o),
  .pin_i(pin_i),
  .pin_drive_o(pin_drive_o)
);
